// *** pkg/tcs_pkg.sv ***
// package: register map, field layout and types of the timer channel status block
package tcs_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TCS_OFS_COMPARE_C = 8'h1C;
    localparam logic [7:0] TCS_OFS_STATUS = 8'h20;
    localparam logic [7:0] TCS_OFS_IRQ_SET = 8'h24;
    localparam logic [7:0] TCS_OFS_IRQ_CLR = 8'h28;
    localparam logic [7:0] TCS_OFS_IRQ_VIEW = 8'h2C;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TCS_NUM_EVT = 8;
    localparam int TCS_BIT_OVERFLOW = 0;
    localparam int TCS_BIT_LOAD_OVERRUN = 1;
    localparam int TCS_BIT_MATCH_A = 2;
    localparam int TCS_BIT_MATCH_B = 3;
    localparam int TCS_BIT_MATCH_C = 4;
    localparam int TCS_BIT_LOAD_A = 5;
    localparam int TCS_BIT_LOAD_B = 6;
    localparam int TCS_BIT_EXT_TRIGGER = 7;
    localparam int TCS_BIT_CLOCK_ON = 16;
    localparam int TCS_BIT_LINE_A = 17;
    localparam int TCS_BIT_LINE_B = 18;
    localparam int TCS_CMP_WIDTH = 16;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TCS_RST_FLAGS = 8'h00;
    localparam logic [7:0] TCS_RST_MASK = 8'h00;
    localparam logic [15:0] TCS_RST_COMPARE_C = 16'h0000;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic ext_trigger;
        logic load_b;
        logic load_a;
        logic match_c;
        logic match_b;
        logic match_a;
        logic overflow;
    } tcs_evt_type;
    typedef struct packed {
        logic waveform_mode;
        logic counter_clock_on;
        logic line_a_level;
        logic line_b_level;
        logic capture_a_read;
        logic capture_b_read;
    } tcs_chan_type;
endpackage

// *** core/tcs_status_irq.sv ***
// module: status flags, interrupt mask and bus slave of one timer channel
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tcs_status_irq (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // channel events and state
    input wire tcs_pkg::tcs_evt_type evt,
    input wire tcs_pkg::tcs_chan_type chan,
    input wire logic [15:0] compare_c_in,
    input wire logic compare_c_load,
    // interrupt
    output logic irq
);
    import tcs_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers for line levels
    // ------------------------------------------------------------
    logic [1:0] line_s1_r;
    logic [1:0] line_s2_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_s1_r <= 2'h0;
            line_s2_r <= 2'h0;
        end else if (clk_en) begin
            line_s1_r <= {chan.line_b_level, chan.line_a_level};
            line_s2_r <= line_s1_r;
        end
    end

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic ph_valid_r;
    logic ph_write_r;
    logic [7:0] ph_addr_r;
    logic take;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r <= 8'h00;
        end else if (clk_en) begin
            ph_valid_r <= take;
            ph_write_r <= hwrite;
            ph_addr_r <= haddr;
        end
    end
    logic wr_set;
    logic wr_clr;
    logic wr_cmp;
    logic rd_stat;
    assign wr_set = ph_valid_r && ph_write_r && (ph_addr_r == TCS_OFS_IRQ_SET);
    assign wr_clr = ph_valid_r && ph_write_r && (ph_addr_r == TCS_OFS_IRQ_CLR);
    assign wr_cmp = ph_valid_r && ph_write_r && (ph_addr_r == TCS_OFS_COMPARE_C);
    assign rd_stat = take && !hwrite && (haddr == TCS_OFS_STATUS);

    // ------------------------------------------------------------
    // compare c register
    // ------------------------------------------------------------
    logic [15:0] compare_c_value_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_c_value_r <= TCS_RST_COMPARE_C;
        end else if (clk_en) begin
            if (compare_c_load) begin
                compare_c_value_r <= compare_c_in;
            end else if (wr_cmp) begin
                compare_c_value_r <= hwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // capture load tracking for overrun
    // ------------------------------------------------------------
    logic unread_a_r;
    logic unread_b_r;
    logic overrun_evt;
    assign overrun_evt = !chan.waveform_mode &&
        ((evt.load_a && unread_a_r && !chan.capture_a_read) ||
         (evt.load_b && unread_b_r && !chan.capture_b_read));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unread_a_r <= 1'b0;
            unread_b_r <= 1'b0;
        end else if (clk_en) begin
            if (evt.load_a && !chan.waveform_mode) begin
                unread_a_r <= 1'b1;
            end else if (chan.capture_a_read) begin
                unread_a_r <= 1'b0;
            end
            if (evt.load_b && !chan.waveform_mode) begin
                unread_b_r <= 1'b1;
            end else if (chan.capture_b_read) begin
                unread_b_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // sticky event flags
    // ------------------------------------------------------------
    logic [7:0] ev_in;
    logic [7:0] flags_r;
    assign ev_in[TCS_BIT_OVERFLOW] = evt.overflow;
    assign ev_in[TCS_BIT_LOAD_OVERRUN] = overrun_evt;
    assign ev_in[TCS_BIT_MATCH_A] = evt.match_a && chan.waveform_mode;
    assign ev_in[TCS_BIT_MATCH_B] = evt.match_b && chan.waveform_mode;
    assign ev_in[TCS_BIT_MATCH_C] = evt.match_c;
    assign ev_in[TCS_BIT_LOAD_A] = evt.load_a && !chan.waveform_mode;
    assign ev_in[TCS_BIT_LOAD_B] = evt.load_b && !chan.waveform_mode;
    assign ev_in[TCS_BIT_EXT_TRIGGER] = evt.ext_trigger;
    genvar gi;
    generate
        for (gi = 0; gi < TCS_NUM_EVT; gi++) begin : g_flag
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flags_r[gi] <= TCS_RST_FLAGS[gi];
                end else if (clk_en) begin
                    if (ev_in[gi]) begin
                        flags_r[gi] <= 1'b1;
                    end else if (rd_stat) begin
                        flags_r[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // mode-gated view of flags
    logic [7:0] flags_view;
    always_comb begin
        flags_view = flags_r;
        if (chan.waveform_mode) begin
            flags_view[TCS_BIT_LOAD_OVERRUN] = 1'b0;
            flags_view[TCS_BIT_LOAD_A] = 1'b0;
            flags_view[TCS_BIT_LOAD_B] = 1'b0;
        end else begin
            flags_view[TCS_BIT_MATCH_A] = 1'b0;
            flags_view[TCS_BIT_MATCH_B] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt mask
    // ------------------------------------------------------------
    logic [7:0] mask_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_r <= TCS_RST_MASK;
        end else if (clk_en) begin
            if (wr_set) begin
                mask_r <= mask_r | hwdata[7:0];
            end else if (wr_clr) begin
                mask_r <= mask_r & ~hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(flags_view & mask_r);
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (haddr == TCS_OFS_STATUS) begin
            rd_nxt[7:0] = flags_view;
            rd_nxt[TCS_BIT_CLOCK_ON] = chan.counter_clock_on;
            rd_nxt[TCS_BIT_LINE_A] = line_s2_r[0];
            rd_nxt[TCS_BIT_LINE_B] = line_s2_r[1];
        end else if (haddr == TCS_OFS_IRQ_VIEW) begin
            rd_nxt[7:0] = mask_r;
        end else if (haddr == TCS_OFS_COMPARE_C) begin
            rd_nxt[15:0] = compare_c_value_r;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (take && !hwrite) begin
                hrdata <= rd_nxt;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_overflow_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt.overflow) |=> flags_r[TCS_BIT_OVERFLOW];
    endproperty
    a_overflow_sticky: assert property (p_overflow_sticky)
        else $error("overflow flag not set");

    property p_read_clears;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && rd_stat && !ev_in[TCS_BIT_MATCH_C]) |=> !flags_r[TCS_BIT_MATCH_C];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not clear flag");

    property p_match_a_gated;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && rd_stat && !chan.waveform_mode)
            |=> hrdata[TCS_BIT_MATCH_B:TCS_BIT_MATCH_A] == 2'h0;
    endproperty
    a_match_a_gated: assert property (p_match_a_gated)
        else $error("match flag visible in capture mode");

    property p_load_gated;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && rd_stat && chan.waveform_mode)
            |=> hrdata[TCS_BIT_LOAD_B:TCS_BIT_LOAD_A] == 2'h0 && !hrdata[TCS_BIT_LOAD_OVERRUN];
    endproperty
    a_load_gated: assert property (p_load_gated)
        else $error("load flag visible in waveform mode");

    property p_mask_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_set) |=> mask_r == ($past(mask_r) | $past(hwdata[7:0]));
    endproperty
    a_mask_set: assert property (p_mask_set)
        else $error("mask set failed");

    property p_mask_clr;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_clr) |=> mask_r == ($past(mask_r) & ~$past(hwdata[7:0]));
    endproperty
    a_mask_clr: assert property (p_mask_clr)
        else $error("mask clear failed");

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        clk_en |=> irq == $past(|(flags_view & mask_r));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level wrong");

    property p_trigger_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt.ext_trigger) ##1 (!rd_stat || !clk_en) |=> flags_r[TCS_BIT_EXT_TRIGGER];
    endproperty
    a_trigger_sticky: assert property (p_trigger_sticky)
        else $error("trigger flag lost");

    property p_match_a_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt.match_a && chan.waveform_mode) |=> flags_r[TCS_BIT_MATCH_A];
    endproperty
    a_match_a_set: assert property (p_match_a_set)
        else $error("match A flag not set");

    property p_match_b_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt.match_b && chan.waveform_mode) |=> flags_r[TCS_BIT_MATCH_B];
    endproperty
    a_match_b_set: assert property (p_match_b_set)
        else $error("match B flag not set");

    property p_match_c_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt.match_c) |=> flags_r[TCS_BIT_MATCH_C];
    endproperty
    a_match_c_set: assert property (p_match_c_set)
        else $error("match C flag not set");

    property p_load_a_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt.load_a && !chan.waveform_mode) |=> flags_r[TCS_BIT_LOAD_A];
    endproperty
    a_load_a_set: assert property (p_load_a_set)
        else $error("load A flag not set");

    property p_load_b_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt.load_b && !chan.waveform_mode) |=> flags_r[TCS_BIT_LOAD_B];
    endproperty
    a_load_b_set: assert property (p_load_b_set)
        else $error("load B flag not set");

    property p_overrun_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !chan.waveform_mode && evt.load_b && unread_b_r && !chan.capture_b_read)
            |=> flags_r[TCS_BIT_LOAD_OVERRUN];
    endproperty
    a_overrun_set: assert property (p_overrun_set)
        else $error("overrun flag not set");

    property p_status_data;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && rd_stat) |=> hrdata[7:0] == $past(flags_view);
    endproperty
    a_status_data: assert property (p_status_data)
        else $error("status read data wrong");

    property p_clock_on_read;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && rd_stat) |=> hrdata[TCS_BIT_CLOCK_ON] == $past(chan.counter_clock_on);
    endproperty
    a_clock_on_read: assert property (p_clock_on_read)
        else $error("clock state bit wrong");

    property p_line_a_read;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && rd_stat) |=> hrdata[TCS_BIT_LINE_A] == $past(line_s2_r[0]);
    endproperty
    a_line_a_read: assert property (p_line_a_read)
        else $error("line A mirror wrong");

    property p_line_b_read;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && rd_stat) |=> hrdata[TCS_BIT_LINE_B] == $past(line_s2_r[1]);
    endproperty
    a_line_b_read: assert property (p_line_b_read)
        else $error("line B mirror wrong");

    property p_mask_view;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && take && !hwrite && haddr == TCS_OFS_IRQ_VIEW)
            |=> hrdata == {24'h000000, $past(mask_r)};
    endproperty
    a_mask_view: assert property (p_mask_view)
        else $error("mask view read wrong");

    property p_compare_c_read;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && take && !hwrite && haddr == TCS_OFS_COMPARE_C)
            |=> hrdata == {16'h0000, $past(compare_c_value_r)};
    endproperty
    a_compare_c_read: assert property (p_compare_c_read)
        else $error("compare C read wrong");
endmodule // tcs_status_irq
`default_nettype wire

// *** bench/tcs_ahb_master.sv ***
// partner model: ahb-lite master in place of the processor side
`timescale 1ns/10ps
`default_nettype none
module tcs_ahb_master (
    // clock
    input wire logic hclk,
    // ahb-lite master
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= adr;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
        // released data no longer shows the last value
        hwdata <= ~wd;
    endtask
endmodule // tcs_ahb_master
`default_nettype wire

// *** bench/tb.sv ***
// testbench: status flags, mask and interrupt of the timer channel block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tcs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, irq, cload;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic [15:0] cin;
    tcs_evt_type evt, e;
    tcs_chan_type chan;
    int fails, cmp_count;
    logic clk_en;
    tcs_status_irq dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .evt(evt),
        .chan(chan), .compare_c_in(cin), .compare_c_load(cload), .irq(irq));
    tcs_ahb_master mst_u (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
        mst_u.xfer(1'b0, a, 32'h0, q);
        chk(n, x, q);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mst_u.xfer(1'b1, a, d, q);
    endtask
    // one-cycle event pulse, then let the flag land
    task automatic pulse(input tcs_evt_type p);
        evt <= p;
        @(posedge hclk);
        evt <= '0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic t_reset();
        rdchk("status", TCS_OFS_STATUS, 32'h0);
        rdchk("mask", TCS_OFS_IRQ_VIEW, 32'h0);
        rdchk("cmpc", TCS_OFS_COMPARE_C, 32'h0);
        rdchk("unmapped", 8'h40, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_cmpc();
        wr(TCS_OFS_COMPARE_C, 32'hFFFF_A5C3);
        rdchk("cmpc", TCS_OFS_COMPARE_C, 32'h0000_A5C3);
        cin <= 16'h3C5A;
        cload <= 1'b1;
        @(posedge hclk);
        cload <= 1'b0;
        @(posedge hclk);
        rdchk("cmpc", TCS_OFS_COMPARE_C, 32'h0000_3C5A);
        $display("test compare done");
    endtask
    task automatic t_wave();
        chan.waveform_mode <= 1'b1;
        pulse('1);
        rdchk("status", TCS_OFS_STATUS, 32'h0000_009D);
        rdchk("status", TCS_OFS_STATUS, 32'h0);
        chan.waveform_mode <= 1'b0;
        $display("test waveform done");
    endtask
    task automatic t_capt();
        e = '0;
        e.load_a = 1'b1;
        pulse(e);
        pulse(e);
        e = '0;
        e.load_b = 1'b1;
        e.match_a = 1'b1;
        e.match_c = 1'b1;
        e.overflow = 1'b1;
        pulse(e);
        rdchk("status", TCS_OFS_STATUS, 32'h0000_0073);
        e = '0;
        e.load_a = 1'b1;
        chan.capture_a_read <= 1'b1;
        @(posedge hclk);
        chan.capture_a_read <= 1'b0;
        pulse(e);
        chan.capture_a_read <= 1'b1;
        @(posedge hclk);
        chan.capture_a_read <= 1'b0;
        pulse(e);
        rdchk("status", TCS_OFS_STATUS, 32'h0000_0020);
        e = '0;
        e.load_b = 1'b1;
        pulse(e);
        rdchk("status", TCS_OFS_STATUS, 32'h0000_0042);
        chan.capture_b_read <= 1'b1;
        @(posedge hclk);
        chan.capture_b_read <= 1'b0;
        pulse(e);
        rdchk("status", TCS_OFS_STATUS, 32'h0000_0040);
        $display("test capture done");
    endtask
    task automatic t_state();
        chan.counter_clock_on <= 1'b1;
        chan.line_a_level <= 1'b1;
        repeat (4) @(posedge hclk);
        rdchk("status", TCS_OFS_STATUS, 32'h0003_0000);
        chan.counter_clock_on <= 1'b0;
        chan.line_a_level <= 1'b0;
        chan.line_b_level <= 1'b1;
        repeat (4) @(posedge hclk);
        rdchk("status", TCS_OFS_STATUS, 32'h0004_0000);
        $display("test state done");
    endtask
    task automatic t_irq();
        wr(TCS_OFS_IRQ_SET, 32'h0000_0081);
        wr(TCS_OFS_IRQ_SET, 32'h0000_0010);
        rdchk("mask", TCS_OFS_IRQ_VIEW, 32'h0000_0091);
        wr(TCS_OFS_IRQ_CLR, 32'h0000_0011);
        rdchk("mask", TCS_OFS_IRQ_VIEW, 32'h0000_0080);
        e = '0;
        e.overflow = 1'b1;
        pulse(e);
        chk("irq", 32'h0, {31'h0, irq});
        e = '0;
        e.ext_trigger = 1'b1;
        pulse(e);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk("status", TCS_OFS_STATUS, 32'h0004_0081);
        repeat (2) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test irq done");
    endtask
    // events while the clock enable is low must leave no trace
    task automatic t_freeze();
        e = '0;
        e.overflow = 1'b1;
        clk_en <= 1'b0;
        pulse(e);
        clk_en <= 1'b1;
        rdchk("status", TCS_OFS_STATUS, 32'h0004_0000);
        $display("test freeze done");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        print_verdict();
    end
    initial begin
        fails = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        evt = '0;
        chan = '0;
        cin = 16'h0;
        cload = 1'b0;
        clk_en = 1'b1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_cmpc();
        t_wave();
        t_capt();
        t_state();
        t_irq();
        t_freeze();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
